/* rtl/system_reset_controller.sv */
// reset sequencer, reset pin driver, cause register and reset-vector fetch
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "reset_ctrl_map.svh"

// Behaviour
// R1 - an outside party holds the reset pin low for the minimum time
// R2 - acting on a reset may wait for the bus cycle or monitor timeout
// R3 - integration pins are held inactive while reset is asserted
// R4 - external reset: keep driving pin 512 cycles after outside release; code counts 512 from drive entry, not from release
// R5 - internal reset drives pin 512 cycles, longer while request persists
// R6 - after each drive period release pin ten cycles, sample, repeat if low
// R7 - power-on asserts both lines; master ends at supply, pin after lock+512
// R8 - peripherals reset only after master line held four clock cycles
// R9 - reset taken at end of bus cycle, aborting work in progress
// R10 - requests are synchronised before master reset is asserted
// R11 - master reset clears trace bits, sets supervisor, mask to seven
// R12 - master reset loads vector base register with zero
// R13 - at master negation the breakpoint input is sampled first
// R14 - reset vector fetch: first word to stack pointer, second to pc
// R15 - vectors come from internal ram or rom via boot chip select
// R16 - then first instruction fetched at loaded pc and decoding starts
// R17 - cause register keeps one bit per source, several may be set
// R18 - cause register is updated when the reset pin is released
// R19 - breakpoint low during reset sets the background debug flag
// R20 - reset pin input passes a two-flop synchroniser before use
module system_reset_controller #(
	parameter logic [15:0] DEFER_MAX_CYC = 16'h0040
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [7:0]                  s_axi_araddr,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	input  wire logic                        reset_pin_in,
	output logic                             reset_pin_out,
	output logic                             reset_pin_oe_n,
	input  wire logic                        supply_ok,
	input  wire logic                        pll_locked,
	input  wire logic [1:0]                  internal_reset_req,
	input  wire logic                        bus_cycle_busy,
	input  wire logic [1:0]                  breakpoint_input,
	output logic                             master_reset_line,
	output logic                             external_reset_line,
	output logic                             peripheral_reset,
	output logic                             pins_inactive,
	output logic                             background_debug_mode,
	output reset_ctrl_pkg::cpu_status_t      cpu_status,
	output logic                             fetch_req,
	output logic [23:0]                      fetch_addr,
	input  wire logic                        fetch_ack,
	input  wire logic [31:0]                 fetch_data,
	output logic                             boot_chip_select_n,
	output logic [31:0]                      stack_pointer,
	output logic [31:0]                      program_counter,
	output logic [31:0]                      first_insn,
	output logic                             decode_start
);
	reset_ctrl_pkg::ctl_t q;
	reset_ctrl_pkg::ctl_t d;
	logic                 pin_s;
	logic                 int_req;
	logic [4:0]           new_cause;
	logic                 wr_ok;
	logic                 rd_ok;
	logic [31:0]          rd_val;

	sync2 #(
		.RST_VAL (1'b1)
	) u_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d_in    (reset_pin_in),
		.q_out   (pin_s)
	); // R20

	always_comb begin
		d = q;
		d.decode_start = 1'b0;
		int_req = (|internal_reset_req) | q.soft_req;
		new_cause = '0;
		new_cause[`CAUSE_SOFT] = q.soft_req;
		new_cause[`CAUSE_INT0] = internal_reset_req[0];
		new_cause[`CAUSE_INT1] = internal_reset_req[1];

		// master hold counter gates peripheral reset
		if (q.master) begin
			if (q.mcnt != `MSTR_MIN_CYC) begin
				d.mcnt = q.mcnt + 3'h1;
			end
		end else begin
			d.mcnt = '0;
		end
		d.periph_rst = q.master && (q.mcnt >= `MSTR_MIN_CYC - 3'h1); // R8

		if (q.master) begin
			d.cpu.trace_bit_one = 1'b0; // R11
			d.cpu.trace_bit_zero = 1'b0; // R11
			d.cpu.supervisor = 1'b1; // R11
			d.cpu.interrupt_priority_mask = `IPM_RESET; // R11
			d.cpu.vector_base_register = `VEC_BASE_RESET; // R12
		end

		// vector and first-instruction fetch, aborted by master reset
		if (q.master) begin
			d.sq = reset_ctrl_pkg::SQ_IDLE; // R9
			d.fetch_req = 1'b0;
			d.boot_cs_n = 1'b1;
		end else begin
			case (q.sq)
			reset_ctrl_pkg::SQ_IDLE: begin
			end
			reset_ctrl_pkg::SQ_SSP: begin
				if (fetch_ack) begin
					d.sp = fetch_data; // R14
					d.fetch_addr = q.cpu.vector_base_register + `PC_VEC_OFS;
					d.sq = reset_ctrl_pkg::SQ_PC;
				end
			end
			reset_ctrl_pkg::SQ_PC: begin
				if (fetch_ack) begin
					d.pc = fetch_data; // R14
					d.fetch_addr = fetch_data[23:0]; // R16
					d.boot_cs_n = 1'b1;
					d.sq = reset_ctrl_pkg::SQ_INSN;
				end
			end
			reset_ctrl_pkg::SQ_INSN: begin
				if (fetch_ack) begin
					d.insn = fetch_data; // R16
					d.fetch_req = 1'b0;
					d.decode_start = 1'b1; // R16
					d.sq = reset_ctrl_pkg::SQ_RUN;
				end
			end
			reset_ctrl_pkg::SQ_RUN: begin
			end
			default: begin
				d.sq = reset_ctrl_pkg::SQ_IDLE;
			end
			endcase
		end

		if (q.st != reset_ctrl_pkg::ST_RUN) begin
			d.cause_pend = q.cause_pend | new_cause; // R17
		end

		case (q.st)
		reset_ctrl_pkg::ST_RUN: begin
			if (!pin_s || int_req) begin // R10
				d.st = reset_ctrl_pkg::ST_DEFER;
				d.defer_cnt = '0;
				d.cause_pend = new_cause; // R17
				d.cause_pend[`CAUSE_EXT] = !pin_s;
			end
		end
		reset_ctrl_pkg::ST_DEFER: begin
			d.defer_cnt = q.defer_cnt + 16'h0001;
			if (!bus_cycle_busy || q.defer_cnt >= DEFER_MAX_CYC - 16'h0001) begin // R2 R9
				d.st = reset_ctrl_pkg::ST_DRIVE;
				d.cnt = '0;
				d.master = 1'b1;
				d.ext_line = 1'b1;
				d.pin_oe_n = 1'b0;
				d.soft_req = 1'b0;
			end
		end
		reset_ctrl_pkg::ST_DRIVE: begin
			if (q.cnt != `DRIVE_CYC - 10'h001) begin
				d.cnt = q.cnt + 10'h001; // R4 R5
			end else if (!int_req) begin // R5
				d.st = reset_ctrl_pkg::ST_RELEASE;
				d.cnt = '0;
				d.pin_oe_n = 1'b1; // R6
			end
		end
		reset_ctrl_pkg::ST_RELEASE: begin
			d.cnt = q.cnt + 10'h001;
			if (q.cnt == `RELEASE_CYC - 10'h001) begin
				if (pin_s) begin // R6
					d.st = reset_ctrl_pkg::ST_RUN;
					d.master = 1'b0;
					d.ext_line = 1'b0;
					d.cause = q.cause_pend | new_cause; // R18
					d.cause_pend = '0;
					d.sq = reset_ctrl_pkg::SQ_SSP;
					d.fetch_req = 1'b1;
					d.fetch_addr = q.cpu.vector_base_register + `SP_VEC_OFS;
					d.boot_cs_n = q.vec_ram; // R15
					if (q.master) begin
						d.dbg = ~&breakpoint_input; // R13 R19
					end
				end else begin
					d.st = reset_ctrl_pkg::ST_DRIVE; // R4 R6
					d.cnt = '0;
					d.pin_oe_n = 1'b0;
				end
			end
		end
		reset_ctrl_pkg::ST_POR: begin
			if (supply_ok && q.mcnt == `MSTR_MIN_CYC) begin // R7 R8
				d.st = reset_ctrl_pkg::ST_LOCK;
				d.master = 1'b0;
				d.cnt = '0;
				d.dbg = ~&breakpoint_input; // R13 R19
			end
		end
		reset_ctrl_pkg::ST_LOCK: begin
			if (!pll_locked) begin
				d.cnt = '0; // R7
			end else if (q.cnt != `DRIVE_CYC - 10'h001) begin
				d.cnt = q.cnt + 10'h001;
			end else begin
				d.st = reset_ctrl_pkg::ST_RELEASE; // R7 R6
				d.cnt = '0;
				d.pin_oe_n = 1'b1;
			end
		end
		default: begin
			d.st = reset_ctrl_pkg::ST_POR;
		end
		endcase

		if (!supply_ok && q.st != reset_ctrl_pkg::ST_POR) begin // R7
			d.st = reset_ctrl_pkg::ST_POR;
			d.master = 1'b1;
			d.ext_line = 1'b1;
			d.pin_oe_n = 1'b0;
			d.cause_pend = q.cause_pend | new_cause;
			d.cause_pend[`CAUSE_POR] = 1'b1;
			d.cnt = '0;
		end
		d.pins_inactive = (d.st != reset_ctrl_pkg::ST_RUN); // R3

		// register bus slave
		if (s_axi_awvalid && q.awready) begin
			d.awaddr = s_axi_awaddr;
			d.awready = 1'b0;
		end
		if (s_axi_wvalid && q.wready) begin
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
			d.wready = 1'b0;
		end
		wr_ok = 1'b0;
		case ({q.awaddr[7:2], 2'b00})
		`OFS_CTRL, `OFS_CAUSE, `OFS_STATUS, `OFS_STACK, `OFS_PC: begin
			wr_ok = 1'b1;
		end
		default: begin
			wr_ok = 1'b0;
		end
		endcase
		if (!q.awready && !q.wready && !q.bvalid) begin
			d.bvalid = 1'b1;
			d.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			if ({q.awaddr[7:2], 2'b00} == `OFS_CTRL && q.wstrb[0]) begin
				// a set from software wins over the clear on drive entry
				d.soft_req = d.soft_req | q.wdata[`CTRL_SOFT_BIT];
				d.vec_ram = q.wdata[`CTRL_RAM_BIT];
			end
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end

		rd_ok = 1'b1;
		rd_val = '0;
		case ({s_axi_araddr[7:2], 2'b00})
		`OFS_CTRL: begin
			rd_val[`CTRL_SOFT_BIT] = q.soft_req;
			rd_val[`CTRL_RAM_BIT] = q.vec_ram;
		end
		`OFS_CAUSE: begin
			rd_val[`CAUSE_W-1:0] = q.cause;
		end
		`OFS_STATUS: begin
			rd_val[5:0] = q.st;
			rd_val[10:6] = q.sq;
			rd_val[11] = q.dbg;
			rd_val[12] = q.master;
			rd_val[13] = !q.pin_oe_n;
			rd_val[14] = pin_s;
			rd_val[15] = q.periph_rst;
		end
		`OFS_STACK: begin
			rd_val = q.sp;
		end
		`OFS_PC: begin
			rd_val = q.pc;
		end
		default: begin
			rd_ok = 1'b0;
		end
		endcase
		if (s_axi_arvalid && q.arready) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = rd_val;
			d.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= reset_ctrl_pkg::ST_POR;
			q.sq <= reset_ctrl_pkg::SQ_IDLE;
			q.master <= 1'b1;
			q.ext_line <= 1'b1;
			q.pins_inactive <= 1'b1;
			q.cause_pend <= 5'h02;
			q.cpu.supervisor <= 1'b1;
			q.cpu.interrupt_priority_mask <= `IPM_RESET;
			q.boot_cs_n <= 1'b1;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready         = q.awready;
	assign s_axi_wready          = q.wready;
	assign s_axi_bvalid          = q.bvalid;
	assign s_axi_bresp           = q.bresp;
	assign s_axi_arready         = q.arready;
	assign s_axi_rvalid          = q.rvalid;
	assign s_axi_rdata           = q.rdata;
	assign s_axi_rresp           = q.rresp;
	assign reset_pin_out         = 1'b0;
	assign reset_pin_oe_n        = q.pin_oe_n;
	assign master_reset_line     = q.master;
	assign external_reset_line   = q.ext_line;
	assign peripheral_reset      = q.periph_rst;
	assign pins_inactive         = q.pins_inactive;
	assign background_debug_mode = q.dbg;
	assign cpu_status            = q.cpu;
	assign fetch_req             = q.fetch_req;
	assign fetch_addr            = q.fetch_addr;
	assign boot_chip_select_n    = q.boot_cs_n;
	assign stack_pointer         = q.sp;
	assign program_counter       = q.pc;
	assign first_insn            = q.insn;
	assign decode_start          = q.decode_start;
endmodule : system_reset_controller

/* rtl/reset_ctrl_map.svh */
// offsets, field positions, reset values and cycle counts of the reset controller
`ifndef RESET_CTRL_MAP_SVH
`define RESET_CTRL_MAP_SVH

`define OFS_CTRL        8'h00
`define OFS_CAUSE       8'h04
`define OFS_STATUS      8'h08
`define OFS_STACK       8'h0c
`define OFS_PC          8'h10

`define CTRL_SOFT_BIT   0
`define CTRL_RAM_BIT    1

`define CAUSE_EXT       0
`define CAUSE_POR       1
`define CAUSE_SOFT      2
`define CAUSE_INT0      3
`define CAUSE_INT1      4
`define CAUSE_W         5

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define DRIVE_CYC       10'h200
`define RELEASE_CYC     10'h00a
`define MSTR_MIN_CYC    3'h4
`define IPM_RESET       3'h7
`define VEC_BASE_RESET  24'h000000
`define SP_VEC_OFS      24'h000000
`define PC_VEC_OFS      24'h000004

`endif

/* rtl/reset_ctrl_pkg.sv */
// types of the reset controller
package reset_ctrl_pkg;

	typedef enum logic [5:0] {
		ST_RUN     = 6'h01,
		ST_DEFER   = 6'h02,
		ST_DRIVE   = 6'h04,
		ST_RELEASE = 6'h08,
		ST_POR     = 6'h10,
		ST_LOCK    = 6'h20
	} rst_state_t;

	typedef enum logic [4:0] {
		SQ_IDLE = 5'h01,
		SQ_SSP  = 5'h02,
		SQ_PC   = 5'h04,
		SQ_INSN = 5'h08,
		SQ_RUN  = 5'h10
	} seq_state_t;

	typedef struct packed {
		logic        trace_bit_one;
		logic        trace_bit_zero;
		logic        supervisor;
		logic [2:0]  interrupt_priority_mask;
		logic [23:0] vector_base_register;
	} cpu_status_t;

	typedef struct packed {
		rst_state_t  st;
		seq_state_t  sq;
		logic [9:0]  cnt;
		logic [15:0] defer_cnt;
		logic [2:0]  mcnt;
		logic [4:0]  cause_pend;
		logic [4:0]  cause;
		logic        master;
		logic        ext_line;
		logic        pin_oe_n;
		logic        periph_rst;
		logic        pins_inactive;
		logic        dbg;
		cpu_status_t cpu;
		logic [31:0] sp;
		logic [31:0] pc;
		logic [31:0] insn;
		logic        fetch_req;
		logic [23:0] fetch_addr;
		logic        boot_cs_n;
		logic        decode_start;
		logic        soft_req;
		logic        vec_ram;
		logic        awready;
		logic        wready;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ctl_t;

endpackage : reset_ctrl_pkg

/* rtl/sync2.sv */
// two-flop synchroniser for a level
`timescale 1ns/1ps
module sync2 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic d_in,
	output logic      q_out
);
	logic [1:0] stage_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage_q <= {2{RST_VAL}};
		end else begin
			stage_q <= {stage_q[0], d_in};
		end
	end

	assign q_out = stage_q[1];
endmodule : sync2

/* tb/reset_ctrl_properties.sv */
// port assertions of the reset controller
`timescale 1ns/1ps
module reset_ctrl_properties (
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic                        supply_ok,
	input wire logic                        bus_cycle_busy,
	input wire logic                        reset_pin_oe_n,
	input wire logic                        master_reset_line,
	input wire logic                        external_reset_line,
	input wire logic                        peripheral_reset,
	input wire logic                        pins_inactive,
	input wire reset_ctrl_pkg::cpu_status_t cpu_status,
	input wire logic                        fetch_req,
	input wire logic [23:0]                 fetch_addr,
	input wire logic                        fetch_ack,
	input wire logic                        decode_start
);
	int unsigned drive_q;

	// cycles the pin has been driven low without a break
	always_ff @(posedge aclk) begin
		if (!aresetn || reset_pin_oe_n)
			drive_q <= 0;
		else
			drive_q <= drive_q + 1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_window;
		reset_pin_oe_n [*8] ##1 reset_pin_oe_n [*2];
	endsequence
	sequence s_pulse;
		$past(fetch_ack) ##1 !decode_start;
	endsequence

	property p_inact;
		master_reset_line |-> pins_inactive;
	endproperty
	property p_periph;
		$rose(peripheral_reset) |->
			$past(master_reset_line) && $past(master_reset_line, 4);
	endproperty
	property p_status;
		master_reset_line [*2] |-> cpu_status.supervisor
			&& cpu_status.interrupt_priority_mask == 3'h7
			&& !cpu_status.trace_bit_zero && !cpu_status.trace_bit_one;
	endproperty
	property p_vec_base;
		master_reset_line |=> cpu_status.vector_base_register == 24'h000000;
	endproperty
	property p_drive;
		$rose(reset_pin_oe_n) |-> drive_q >= 512;
	endproperty
	property p_window;
		$rose(reset_pin_oe_n) |-> s_window;
	endproperty
	property p_release;
		$fell(external_reset_line) |-> reset_pin_oe_n
			&& $past(reset_pin_oe_n, 8) && !master_reset_line;
	endproperty
	property p_master_rise;
		$rose(master_reset_line) |-> $past(pins_inactive) || !$past(supply_ok);
	endproperty
	property p_defer;
		$rose(master_reset_line) |-> !$past(supply_ok)
			|| !$past(bus_cycle_busy) || $past(pins_inactive, 4);
	endproperty
	property p_vec;
		$rose(fetch_req) |-> !master_reset_line
			&& fetch_addr == cpu_status.vector_base_register;
	endproperty
	property p_decode;
		decode_start |-> s_pulse;
	endproperty

	a_inact: assert property (p_inact)
		else $error("pins active during master reset");
	a_periph: assert property (p_periph)
		else $error("peripheral reset before four master cycles");
	a_status: assert property (p_status)
		else $error("status not initialised by master reset");
	a_vec_base: assert property (p_vec_base)
		else $error("vector base not zero");
	a_drive: assert property (p_drive)
		else $error("reset pin drive shorter than 512 cycles");
	a_window: assert property (p_window)
		else $error("release window cut short");
	a_release: assert property (p_release)
		else $error("reset line fell outside release window");
	a_master_rise: assert property (p_master_rise)
		else $error("master reset raised without synchronised request");
	a_defer: assert property (p_defer)
		else $error("master reset raised inside a busy bus cycle");
	a_vec: assert property (p_vec)
		else $error("first fetch not at vector base");
	a_decode: assert property (p_decode)
		else $error("decode start not a pulse after fetch");
endmodule : reset_ctrl_properties

bind system_reset_controller reset_ctrl_properties i_props (
	.aclk(aclk), .aresetn(aresetn), .reset_pin_oe_n(reset_pin_oe_n),
	.supply_ok(supply_ok), .bus_cycle_busy(bus_cycle_busy),
	.master_reset_line(master_reset_line),
	.external_reset_line(external_reset_line),
	.peripheral_reset(peripheral_reset), .pins_inactive(pins_inactive),
	.cpu_status(cpu_status), .fetch_req(fetch_req),
	.fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
	.decode_start(decode_start)
);

/* tb/ext_reset_src.sv */
// outside device sharing the pulled-up reset wire
`timescale 1ns/1ps
module ext_reset_src (
	input  wire logic aclk,
	input  wire logic hold,
	input  wire logic dev_out,
	input  wire logic dev_oe_n,
	output logic      pin
);
	logic hold_q = 1'b0;

	// request held whole cycles, as long as the bench commands
	always_ff @(posedge aclk) hold_q <= hold;
	assign pin = (hold_q || (!dev_oe_n && !dev_out)) ? 1'b0 : 1'b1;
endmodule : ext_reset_src

/* tb/tb_top.sv */
// self-checking bench of the reset controller
`timescale 1ns/1ps
`include "reset_ctrl_map.svh"
module tb_top;
	logic        aclk, aresetn, awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
	logic        pin, pout, oe_n, sup, lock, busy, master, ext, per, inact;
	logic        dbg, freq, fack, boot_n, dec, hold, ram;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, fdata, sp, pc, insn, rd, seed, sp_v, pc_v, insn_v;
	logic [3:0]  ws;
	logic [1:0]  br, rr, rresp, ireq, brk;
	logic [23:0] faddr;
	logic [23:0] addrs[$];
	reset_ctrl_pkg::cpu_status_t cpu;
	int          fails, tests_run, cyc;

	system_reset_controller #(.DEFER_MAX_CYC(16'h0004)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .reset_pin_in(pin), .reset_pin_out(pout),
		.reset_pin_oe_n(oe_n), .supply_ok(sup), .pll_locked(lock),
		.internal_reset_req(ireq), .bus_cycle_busy(busy),
		.breakpoint_input(brk), .master_reset_line(master),
		.external_reset_line(ext), .peripheral_reset(per),
		.pins_inactive(inact), .background_debug_mode(dbg),
		.cpu_status(cpu), .fetch_req(freq), .fetch_addr(faddr),
		.fetch_ack(fack), .fetch_data(fdata), .boot_chip_select_n(boot_n),
		.stack_pointer(sp), .program_counter(pc), .first_insn(insn),
		.decode_start(dec)
	);
	ext_reset_src i_ext (.aclk(aclk), .hold(hold), .dev_out(pout),
		.dev_oe_n(oe_n), .pin(pin));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic chk(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		bit a_on, w_on;
		a_on = 1;
		w_on = 1;
		awa <= a;
		wd <= d;
		ws <= 4'hf;
		awv <= 1'b1;
		wv <= 1'b1;
		while (a_on || w_on) begin
			@(posedge aclk);
			if (a_on && awr === 1'b1) begin
				a_on = 0;
				awv <= 1'b0;
			end
			if (w_on && wr === 1'b1) begin
				w_on = 0;
				wv <= 1'b0;
			end
		end
		brdy <= 1'b1;
		do @(posedge aclk); while (bv !== 1'b1);
		chk(br === (a > `OFS_PC ? `RESP_SLVERR : `RESP_OKAY), "write resp");
		brdy <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		do @(posedge aclk); while (arr !== 1'b1);
		arv <= 1'b0;
		rrdy <= 1'b1;
		do @(posedge aclk); while (rv !== 1'b1);
		rd = rdat;
		rr = rresp;
		rrdy <= 1'b0;
	endtask : axi_read

	task automatic prep;
		seed = xs(seed);
		sp_v = seed;
		seed = xs(seed);
		pc_v = seed | 32'h100;
		seed = xs(seed);
		insn_v = seed;
		addrs.delete();
	endtask : prep

	task automatic run_reset(input logic [4:0] c, input logic b);
		while (dec !== 1'b1) @(posedge aclk);
		chk(sp === sp_v && pc === pc_v, "vector words");
		chk(insn === insn_v && addrs.size() == 3, "first insn");
		chk(addrs[0] === 24'h0 && addrs[1] === 24'h4
			&& addrs[2] === pc_v[23:0], "fetch order");
		chk(master === 1'b0 && dbg === b, "master or debug flag");
		axi_read(`OFS_CAUSE);
		chk(rd[4:0] === c && rr === `RESP_OKAY, "cause");
	endtask : run_reset

	always #25 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		busy <= cyc[3] & cyc[1];
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end

	// fetch responder with gaps between acknowledges
	always @(posedge aclk) begin
		fack <= 1'b0;
		if (freq === 1'b1 && fack !== 1'b1 && cyc[0]) begin
			chk(boot_n === ((addrs.size() < 2 && !ram) ? 1'b0 : 1'b1),
				"boot select");
			fdata <= addrs.size() == 0 ? sp_v
				: addrs.size() == 1 ? pc_v : insn_v;
			addrs.push_back(faddr);
			fack <= 1'b1;
		end
	end

	initial begin
		aclk = 0; aresetn = 0; awv = 0; wv = 0; brdy = 0; arv = 0; rrdy = 0;
		awa = 0; ara = 0; wd = 0; ws = 0; sup = 1; lock = 1; busy = 0;
		ireq = 0; brk = 2'b11; hold = 0; fack = 0; fdata = 0; ram = 0;
		cyc = 0; fails = 0; tests_run = 0; seed = 32'hb615;
		prep();
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		run_reset(5'h02, 1'b0);
		prep();
		brk <= 2'b01;
		ireq <= 2'b01;
		repeat (690) @(posedge aclk);
		chk(oe_n === 1'b0, "pin released while request held");
		axi_read(`OFS_CAUSE);
		chk(rd[4:0] === 5'h02, "cause changed during reset");
		ireq <= 2'b00;
		run_reset(5'h08, 1'b1);
		brk <= 2'b11;
		prep();
		ram <= 1'b1;
		axi_write(`OFS_CTRL, 32'h3);
		ireq <= 2'b10;
		repeat (20) @(posedge aclk);
		ireq <= 2'b00;
		run_reset(5'h14, 1'b0);
		ram <= 1'b0;
		axi_write(`OFS_CTRL, 32'h0);
		prep();
		seed = xs(seed);
		hold <= 1'b1;
		repeat (1100 + seed[7:0]) @(posedge aclk);
		hold <= 1'b0;
		run_reset(5'h01, 1'b0);
		axi_read(8'h40);
		chk(rr === `RESP_SLVERR && rd === 32'h0, "unmapped read");
		axi_write(8'h40, 32'h1);
		axi_write(`OFS_CAUSE, 32'h1f);
		axi_read(`OFS_CAUSE);
		chk(rd[4:0] === 5'h01, "cause overwritten by bus");
		prep();
		sup <= 1'b0;
		lock <= 1'b0;
		repeat (8) @(posedge aclk);
		sup <= 1'b1;
		repeat (300) @(posedge aclk);
		chk(ext === 1'b1 && master === 1'b0, "pin before lock");
		lock <= 1'b1;
		run_reset(5'h02, 1'b0);
		final_report();
	end
endmodule : tb_top
